// File: design/rtc_pkg.sv
// rtc_pkg: constants and types shared by the record and transfer control block.
// assumes a 32-bit register bus where each register occupies one aligned word,
// with the byte address equal to four times the register index.
package rtc_pkg;

   // ------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [17:0] IDX_CARD_COMMAND = 18'd100;
   localparam logic [17:0] IDX_CARD_STATUS = 18'd110;
   localparam logic [17:0] IDX_OPERATING_MODE = 18'd9500;
   localparam logic [17:0] IDX_RECORD_LEN_LO = 18'd10000;
   localparam logic [17:0] IDX_RECORD_LEN_HI = 18'd10001;
   localparam logic [17:0] IDX_POST_TRIG_LO = 18'd10100;
   localparam logic [17:0] IDX_POST_TRIG_HI = 18'd10101;
   localparam logic [17:0] IDX_BUF_DEFINE = 18'd20000;
   localparam logic [17:0] IDX_BUF_INVALIDATE = 18'd20001;
   localparam logic [17:0] IDX_NOTIFY_SIZE = 18'd20002;
   localparam logic [17:0] IDX_XFER_LEN = 18'd20003;
   localparam logic [17:0] IDX_WAIT_TIMEOUT = 18'd20004;
   localparam logic [17:0] IDX_TEST_ADDR = 18'd20005;
   localparam logic [17:0] IDX_TEST_DATA = 18'd20006;
   localparam logic [17:0] IDX_AVAIL_BYTES = 18'd20007;
   localparam logic [17:0] IDX_MEMORY_TEST = 18'd200700;

   // ------------------------------------------------------------
   // command bits, status bits, codes
   // ------------------------------------------------------------
   localparam logic [31:0] CMD_RECORD_START = 32'h0000_0004;
   localparam logic [31:0] CMD_XFER_START = 32'h0001_0000;
   localparam logic [31:0] CMD_XFER_WAIT = 32'h0002_0000;
   localparam logic [31:0] CMD_XFER_STOP = 32'h0004_0000;
   localparam int ST_TRIGGER_SEEN = 0;
   localparam int ST_RECORD_DONE = 1;
   localparam int ST_ARMED = 2;
   localparam int ST_BLOCK_READY = 8;
   localparam int ST_XFER_DONE = 9;
   localparam int ST_OVERRUN = 10;
   localparam int ST_XFER_ERROR = 11;
   localparam int ST_WAIT_TIMEOUT = 12;
   localparam logic [31:0] MODE_SINGLE_RECORD = 32'h0000_0001;
   localparam logic [15:0] BUF_SAMPLE_DATA = 16'd1000;
   localparam logic [15:0] BUF_SLOW_RATE = 16'd2000;
   localparam logic [15:0] BUF_TIMESTAMP = 16'd3000;

   // ------------------------------------------------------------
   // sizes, reset values, timing
   // ------------------------------------------------------------
   localparam int MEM_DEPTH = 64;
   localparam logic [6:0] MEM_DEPTH_W = 7'd64;
   localparam logic [31:0] BYTES_PER_SAMPLE = 32'h0000_0002;
   localparam logic [3:0] SAMPLE_DIV = 4'h4;
   localparam logic [31:0] RESET_MODE = 32'h0000_0001;
   localparam logic [63:0] RESET_RECORD_LEN = 64'h0000_0000_0000_0040;
   localparam logic [63:0] RESET_POST_TRIG = 64'h0000_0000_0000_0020;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      REC_IDLE = 5'b00001,
      REC_FILL = 5'b00010,
      REC_ARMED = 5'b00100,
      REC_POST = 5'b01000,
      REC_DONE = 5'b10000
   } rtc_rec_t;

   typedef enum logic [2:0] {
      DMA_IDLE = 3'b001,
      DMA_PEND = 3'b010,
      DMA_RUN = 3'b100
   } rtc_dma_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rtc_beat_t;

   typedef struct packed {
      logic blockReady;
      logic xferDone;
      logic overrun;
      logic xferError;
      logic waitTimeout;
   } rtc_flags_t;

   typedef struct packed {
      logic waitReq;
      logic [31:0] rdData;
      logic taken;
      logic waitPend;
      logic [31:0] waitCnt;
      logic [31:0] mode;
      logic [63:0] recLen;
      logic [63:0] postTrig;
      logic memTest;
      logic [5:0] testAddr;
      logic [15:0] bufType;
      logic bufValid;
      logic [31:0] notifySize;
      logic [31:0] xferLen;
      logic [31:0] timeout;
      rtc_rec_t rec;
      logic [3:0] divCnt;
      logic [5:0] wrPtr;
      logic [6:0] fillCnt;
      logic [6:0] postLeft;
      logic trigSeen;
      rtc_dma_t dma;
      logic [5:0] rdPtr;
      logic [31:0] bytesLeft;
      logic [31:0] notifyCnt;
      logic [31:0] availBytes;
      rtc_flags_t flags;
      rtc_beat_t beat;
      logic [MEM_DEPTH-1:0][15:0] mem;
   } rtc_state_t;

endpackage

// File: design/rtc_record_dma.sv
// rtc_record_dma: single-shot ring recording into sample memory and the
// transfer of that memory to the host as a stream of 16-bit beats.
// assumes an Avalon-MM master with waitrequest, a sample source valid on
// every sample tick, and a host-side sink that can stall with dmaReady.
//
// Contract
// RULE1: write-only command register, bits act together
// RULE2: transfer start waits for trigger when recording
// RULE3: wait command holds bus until end/notify/timeout
// RULE4: stop command aborts transfer, data invalid
// RULE5: read-only status register returns current flags
// RULE6: block ready once notify bytes available
// RULE7: transfer done only with zero notify size
// RULE8: overrun flag only for FIFO transfers
// RULE9: internal transfer fault sets error flag
// RULE10: buffer invalidated on completion or redefinition
// RULE11: buffer type codes 1000, 2000, 3000
// RULE12: host stops transfer before invalidating buffer
// RULE13: ring recording until trigger, then post count
// RULE14: trigger disarmed until pretrigger area filled
// RULE15: mode register readable, code 1 single record
// RULE16: record length register, samples, read/write
// RULE17: post-trigger count register, read/write
// RULE18: pretrigger equals length minus post-trigger
// RULE19: samples taken at strictly equidistant intervals
// RULE20: memory test mode, random access, commands ignored
// RULE21: zero notify runs to end, one event
// RULE22: transfer flags cleared on new transfer start
// RULE23: start without defined buffer ignored, error set
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps

module rtc_record_dma
   import rtc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register bus, Avalon-MM slave
   input wire logic [19:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // sampling front end
   input wire logic [15:0] sampleData,
   input wire logic triggerIn,
   // transfer stream toward host memory
   output logic dmaValid,
   output logic [15:0] dmaData,
   input wire logic dmaReady
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // usable ring length; zero or oversize lengths fall back to full memory
   function automatic logic [6:0] ringLen(input logic [63:0] len);
      if (len == 64'h0 || len > {57'h0, MEM_DEPTH_W})
         return MEM_DEPTH_W;
      return len[6:0];
   endfunction

   // post-trigger count clipped to the ring length
   function automatic logic [6:0] postLen(input logic [63:0] post, input logic [6:0] len);
      if (post > {57'h0, len})
         return len;
      return post[6:0];
   endfunction

   // ring pointer advance, wrapping at the programmed length
   function automatic logic [5:0] nextPtr(input logic [5:0] p, input logic [6:0] len);
      if ({1'b0, p} + 7'h01 >= len)
         return 6'h00;
      return p + 6'h01;
   endfunction

   // byte-enable merge of a bus write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      return r;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   rtc_state_t s_q; // all registered state of the block
   rtc_state_t s_d; // next value of the state
   logic [17:0] regIdx; // word index of the current access
   logic addrOk; // access is word aligned
   logic [6:0] effLen; // ring length in samples
   logic [6:0] effPost; // post-trigger samples
   logic [6:0] preLen; // pretrigger samples
   logic sampleTick; // one-cycle sample enable
   logic [31:0] statusWord; // assembled status register value
   logic [31:0] cmdWord; // command bits of this write

   assign regIdx = avs_address[19:2];
   assign addrOk = (avs_address[1:0] == 2'b00);
   assign effLen = ringLen(s_q.recLen);
   assign effPost = postLen(s_q.postTrig, effLen);
   assign preLen = effLen - effPost; // RULE18
   assign sampleTick = (s_q.divCnt == SAMPLE_DIV - 4'h1);

   // status word; flags are sticky until the next transfer start
   always_comb
   begin
      statusWord = 32'h0;
      statusWord[ST_TRIGGER_SEEN] = s_q.trigSeen;
      statusWord[ST_RECORD_DONE] = (s_q.rec == REC_DONE);
      statusWord[ST_ARMED] = (s_q.rec == REC_ARMED);
      statusWord[ST_BLOCK_READY] = s_q.flags.blockReady;
      statusWord[ST_XFER_DONE] = s_q.flags.xferDone;
      statusWord[ST_OVERRUN] = s_q.flags.overrun;
      statusWord[ST_XFER_ERROR] = s_q.flags.xferError;
      statusWord[ST_WAIT_TIMEOUT] = s_q.flags.waitTimeout;
   end

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      cmdWord = merge(32'h0, avs_writedata, avs_byteenable);
      s_d.waitReq = 1'b1;

      // sample divider: fixed period independent of bus traffic
      if (sampleTick)
         s_d.divCnt = 4'h0; // RULE19
      else
         s_d.divCnt = s_q.divCnt + 4'h1;

      // recording engine
      unique case (s_q.rec)
         REC_IDLE:
         begin
            // waits for the record start command
         end
         REC_FILL:
         begin
            // pretrigger area fills first; trigger ignored meanwhile
            if (sampleTick)
            begin
               s_d.mem[s_q.wrPtr] = sampleData; // RULE13
               s_d.wrPtr = nextPtr(s_q.wrPtr, effLen);
               s_d.fillCnt = s_q.fillCnt + 7'h01;
               if (s_q.fillCnt + 7'h01 >= preLen)
                  s_d.rec = REC_ARMED; // RULE14
            end
         end
         REC_ARMED:
         begin
            if (sampleTick)
            begin
               s_d.mem[s_q.wrPtr] = sampleData; // RULE13
               s_d.wrPtr = nextPtr(s_q.wrPtr, effLen);
            end
            if (triggerIn)
            begin
               s_d.trigSeen = 1'b1;
               s_d.postLeft = effPost;
               s_d.rec = (effPost == 7'h00) ? REC_DONE : REC_POST; // RULE13
            end
         end
         REC_POST:
         begin
            // post-trigger samples, then recording stops
            if (sampleTick)
            begin
               s_d.mem[s_q.wrPtr] = sampleData;
               s_d.wrPtr = nextPtr(s_q.wrPtr, effLen);
               s_d.postLeft = s_q.postLeft - 7'h01;
               if (s_q.postLeft == 7'h01)
                  s_d.rec = REC_DONE; // RULE13
            end
         end
         REC_DONE:
         begin
            // memory holds the finished ring until the next start
         end
      endcase

      // transfer engine; output beat held until the sink takes it or a stop command drops it
      if (s_q.beat.valid && dmaReady)
      begin
         s_d.beat.valid = 1'b0;
         s_d.availBytes = s_q.availBytes + BYTES_PER_SAMPLE;
         s_d.notifyCnt = s_q.notifyCnt + BYTES_PER_SAMPLE;
         if (s_q.notifySize != 32'h0 && s_q.notifyCnt + BYTES_PER_SAMPLE >= s_q.notifySize)
         begin
            s_d.flags.blockReady = 1'b1; // RULE6
            s_d.notifyCnt = 32'h0;
         end
      end
      unique case (s_q.dma)
         DMA_IDLE:
         begin
            // nothing moving
         end
         DMA_PEND:
         begin
            // start is held off until the recording has finished
            if (s_q.rec == REC_DONE)
            begin
               s_d.dma = DMA_RUN; // RULE2
               s_d.rdPtr = s_q.wrPtr;
            end
         end
         DMA_RUN:
         begin
            if (s_q.bytesLeft != 32'h0 && (!s_q.beat.valid || dmaReady))
            begin
               s_d.beat.valid = 1'b1;
               s_d.beat.data = s_q.mem[s_q.rdPtr];
               s_d.rdPtr = nextPtr(s_q.rdPtr, effLen);
               s_d.bytesLeft = (s_q.bytesLeft <= BYTES_PER_SAMPLE) ? 32'h0 : s_q.bytesLeft - BYTES_PER_SAMPLE;
            end
            else if (s_q.bytesLeft == 32'h0 && (!s_q.beat.valid || dmaReady))
            begin
               s_d.dma = DMA_IDLE;
               s_d.bufValid = 1'b0; // RULE10
               if (s_q.notifySize == 32'h0)
                  s_d.flags.xferDone = 1'b1; // RULE7 RULE21
            end
         end
         default:
         begin
            s_d.dma = DMA_IDLE;
         end
      endcase
      // no FIFO mode exists here, so neither overrun nor underrun can occur
      s_d.flags.overrun = 1'b0; // RULE8

      // wait command: hold the bus answer until a release condition
      if (s_q.waitPend)
      begin
         s_d.waitCnt = s_q.waitCnt + 32'h1;
         if (s_q.dma == DMA_IDLE || s_q.flags.blockReady)
            s_d.waitPend = 1'b0; // RULE3
         else if (s_q.timeout != 32'h0 && s_q.waitCnt + 32'h1 >= s_q.timeout)
         begin
            s_d.waitPend = 1'b0; // RULE3
            s_d.flags.waitTimeout = 1'b1;
         end
      end

      // register bus: a request is taken once on its first cycle
      if ((avs_read || avs_write) && s_q.waitReq && !s_q.taken)
      begin
         s_d.taken = 1'b1;
         if (avs_write && addrOk)
         begin
            unique case (regIdx)
               IDX_CARD_COMMAND:
               begin
                  // each of the four command bits is decoded on its own, so combined commands all act; ignored in test mode
                  if (!s_q.memTest) // RULE20
                  begin
                     if ((cmdWord & CMD_RECORD_START) != 32'h0) // RULE1
                     begin
                        s_d.rec = (preLen == 7'h00) ? REC_ARMED : REC_FILL; // RULE14
                        s_d.wrPtr = 6'h00;
                        s_d.fillCnt = 7'h00;
                        s_d.trigSeen = 1'b0;
                     end
                     if ((cmdWord & CMD_XFER_START) != 32'h0) // RULE1
                     begin
                        s_d.flags = s_d.flags & ~s_q.flags; // RULE22
                        s_d.availBytes = 32'h0;
                        s_d.notifyCnt = 32'h0;
                        if (!s_q.bufValid)
                           s_d.flags.xferError = 1'b1; // RULE23
                        else if (s_q.bufType != BUF_SAMPLE_DATA
                           || s_q.xferLen > {24'h0, effLen, 1'b0})
                           s_d.flags.xferError = 1'b1; // RULE9
                        else
                        begin
                           s_d.bytesLeft = s_q.xferLen;
                           s_d.rdPtr = s_q.wrPtr;
                           if (s_q.mode == MODE_SINGLE_RECORD && s_d.rec != REC_DONE)
                              s_d.dma = DMA_PEND; // RULE2
                           else
                              s_d.dma = DMA_RUN;
                        end
                     end
                     if ((cmdWord & CMD_XFER_STOP) != 32'h0) // RULE1
                     begin
                        s_d.dma = DMA_IDLE; // RULE4
                        s_d.bufValid = 1'b0; // RULE4
                        s_d.bytesLeft = 32'h0;
                        s_d.beat.valid = 1'b0;
                     end
                     if ((cmdWord & CMD_XFER_WAIT) != 32'h0) // RULE1
                     begin
                        s_d.waitPend = 1'b1; // RULE3
                        s_d.waitCnt = 32'h0;
                     end
                  end
               end
               IDX_OPERATING_MODE: s_d.mode = merge(s_q.mode, avs_writedata, avs_byteenable); // RULE15
               IDX_RECORD_LEN_LO: s_d.recLen[31:0] = merge(s_q.recLen[31:0], avs_writedata, avs_byteenable); // RULE16
               IDX_RECORD_LEN_HI: s_d.recLen[63:32] = merge(s_q.recLen[63:32], avs_writedata, avs_byteenable);
               IDX_POST_TRIG_LO: s_d.postTrig[31:0] = merge(s_q.postTrig[31:0], avs_writedata, avs_byteenable); // RULE17
               IDX_POST_TRIG_HI: s_d.postTrig[63:32] = merge(s_q.postTrig[63:32], avs_writedata, avs_byteenable);
               IDX_BUF_DEFINE:
               begin
                  // a new definition replaces any earlier one, whatever its kind
                  if (avs_writedata[15:0] == BUF_SAMPLE_DATA || avs_writedata[15:0] == BUF_SLOW_RATE
                     || avs_writedata[15:0] == BUF_TIMESTAMP) // RULE11
                  begin
                     s_d.bufType = avs_writedata[15:0];
                     s_d.bufValid = 1'b1; // RULE10
                  end
               end
               IDX_BUF_INVALIDATE:
               begin
                  // only the type used at definition invalidates
                  if (avs_writedata[15:0] == s_q.bufType)
                     s_d.bufValid = 1'b0; // RULE10
               end
               IDX_NOTIFY_SIZE: s_d.notifySize = merge(s_q.notifySize, avs_writedata, avs_byteenable);
               IDX_XFER_LEN: s_d.xferLen = merge(s_q.xferLen, avs_writedata, avs_byteenable);
               IDX_WAIT_TIMEOUT: s_d.timeout = merge(s_q.timeout, avs_writedata, avs_byteenable);
               IDX_TEST_ADDR: s_d.testAddr = avs_writedata[5:0];
               IDX_TEST_DATA:
               begin
                  if (s_q.memTest)
                     s_d.mem[s_q.testAddr] = avs_writedata[15:0]; // RULE20
               end
               IDX_MEMORY_TEST: s_d.memTest = avs_writedata[0]; // RULE20
               default:
               begin
                  // unmapped or read-only: write dropped, still answered
               end
            endcase
         end
      end

      // answer once no wait is outstanding; read data loaded with the answer
      if ((avs_read || avs_write) && s_q.waitReq && (s_q.taken || s_d.taken) && !s_d.waitPend)
      begin
         s_d.waitReq = 1'b0;
         s_d.rdData = 32'h0;
         if (avs_read && addrOk)
         begin
            unique case (regIdx)
               IDX_CARD_STATUS: s_d.rdData = statusWord; // RULE5
               IDX_OPERATING_MODE: s_d.rdData = s_q.mode; // RULE15
               IDX_RECORD_LEN_LO: s_d.rdData = s_q.recLen[31:0]; // RULE16
               IDX_RECORD_LEN_HI: s_d.rdData = s_q.recLen[63:32];
               IDX_POST_TRIG_LO: s_d.rdData = s_q.postTrig[31:0]; // RULE17
               IDX_POST_TRIG_HI: s_d.rdData = s_q.postTrig[63:32];
               IDX_BUF_DEFINE: s_d.rdData = {15'h0, s_q.bufValid, s_q.bufType};
               IDX_NOTIFY_SIZE: s_d.rdData = s_q.notifySize;
               IDX_XFER_LEN: s_d.rdData = s_q.xferLen;
               IDX_WAIT_TIMEOUT: s_d.rdData = s_q.timeout;
               IDX_TEST_ADDR: s_d.rdData = {26'h0, s_q.testAddr};
               IDX_TEST_DATA: s_d.rdData = {16'h0, s_q.mem[s_q.testAddr]}; // RULE20
               IDX_AVAIL_BYTES: s_d.rdData = s_q.availBytes;
               IDX_MEMORY_TEST: s_d.rdData = {31'h0, s_q.memTest};
               default: s_d.rdData = 32'h0; // command register and holes read zero
            endcase
         end
      end

      // acceptance edge: the master releases after this cycle
      if (!s_q.waitReq)
         s_d.taken = 1'b0;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.waitReq <= 1'b1;
         s_q.mode <= RESET_MODE;
         s_q.recLen <= RESET_RECORD_LEN;
         s_q.postTrig <= RESET_POST_TRIG;
         s_q.rec <= REC_IDLE;
         s_q.dma <= DMA_IDLE;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs, straight from the state register
   // ------------------------------------------------------------
   assign avs_readdata = s_q.rdData;
   assign avs_waitrequest = s_q.waitReq;
   assign dmaValid = s_q.beat.valid;
   assign dmaData = s_q.beat.data;

endmodule // rtc_record_dma

// File: sim/rtc_host_sink.sv
// rtc_host_sink: host memory side of the beat stream.
// assumes a beat is taken on a rising edge with valid and ready high.
`timescale 1ns/1ps
module rtc_host_sink
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // beat stream
   input wire logic dmaValid,
   output logic dmaReady,
   // bench control
   input wire logic stall,
   output int beats
);
   // ready lags stall by one edge, as a busy host would
   always_ff @(posedge clock)
   begin
      dmaReady <= !stall && !reset;
      if (reset)
         beats <= 0;
      else if (dmaValid && dmaReady)
         beats <= beats + 1;
   end
endmodule // rtc_host_sink

// File: sim/rtc_record_dma_monitor.sv
// rtc_record_dma_monitor: bus and stream checks.
// assumes it sees only the ports of rtc_record_dma.
`timescale 1ns/1ps
module rtc_record_dma_monitor
   import rtc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register bus
   input wire logic [19:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // beat stream
   input wire logic dmaValid,
   input wire logic [15:0] dmaData,
   input wire logic dmaReady
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // a read seen before its answer, then a one-cycle answer
   sequence s_rdReq; avs_read && avs_waitrequest; endsequence
   sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
   // stop bit taken at its request edge
   wire stopWr = avs_write && avs_waitrequest && avs_byteenable[2] && avs_writedata[18]
      && avs_address == {IDX_CARD_COMMAND, 2'b00};
   a_read_answer: assert property (s_rdReq |=> s_answer) else $error("read not answered");
   a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
   a_answer_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("stray answer");
   a_status_overrun: assert property (s_rdReq ##0 avs_address == {IDX_CARD_STATUS, 2'b00}
      |=> !avs_readdata[10]) else $error("overrun set");
   a_command_wo: assert property (s_rdReq ##0 avs_address == {IDX_CARD_COMMAND, 2'b00}
      |=> avs_readdata == 32'h0) else $error("command readable");
   a_beat_hold: assert property (dmaValid && !dmaReady && !stopWr |=> dmaValid && $stable(dmaData))
      else $error("beat lost");
   a_stop_drop: assert property (stopWr |=> !dmaValid) else $error("stop ignored");
   a_reset_idle: assert property ($fell(reset) |-> avs_waitrequest && !dmaValid) else $error("busy after reset");
endmodule // rtc_record_dma_monitor
bind rtc_record_dma rtc_record_dma_monitor rtc_record_dma_monitor_inst (.clock, .reset, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .dmaValid, .dmaData, .dmaReady);

// File: sim/testbench.sv
// testbench: register bus tests of the record and transfer control block.
// assumes rtc_host_sink as beat sink and the bound monitor.
`timescale 1ns/1ps
module testbench
   import rtc_pkg::*;
;
   logic clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, triggerIn = 1'b0, stall = 1'b0;
   logic avs_waitrequest, dmaValid, dmaReady;
   logic [19:0] avs_address = 20'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [15:0] sampleData = 16'h0, dmaData, prevBeat;
   int beats, nb, n_errors = 0, comparisons = 0;
   rtc_record_dma rtc_record_dma_inst (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .sampleData, .triggerIn, .dmaValid, .dmaData, .dmaReady);
   rtc_host_sink rtc_host_sink_inst (.clock, .reset, .dmaValid, .dmaReady, .stall, .beats);
   initial
   begin
      forever #12.5 clock = ~clock;
   end
   // ramp source
   always @(posedge clock) sampleData <= sampleData + 16'h1;
   // beat spacing
   always @(posedge clock)
      if (dmaValid && dmaReady)
      begin
         if (beats inside {[1:7]})
            chk("step", 32'(SAMPLE_DIV), 32'(dmaData - prevBeat));
         prevBeat <= dmaData;
      end
   // one request, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rchk(input logic [17:0] idx, input logic [31:0] m, input logic [31:0] exp, input string name);
      bus(1'b0, idx, 32'h0);
      chk(name, exp, rd & m);
   endtask
   // bounded poll of one status bit
   task automatic poll(input int b);
      rd = 32'h0;
      for (int i = 0; i < 400 && rd[b] !== 1'b1; i++)
         bus(1'b0, IDX_CARD_STATUS, 32'h0);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rchk(IDX_OPERATING_MODE, '1, MODE_SINGLE_RECORD, "mode");
      rchk(IDX_RECORD_LEN_LO, '1, 32'h40, "length");
      bus(1'b1, IDX_POST_TRIG_LO, 32'h18);
      rchk(IDX_POST_TRIG_LO, '1, 32'h18, "post");
      rchk(IDX_CARD_COMMAND, '1, 32'h0, "command");
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_START);
      rchk(IDX_CARD_STATUS, '1, 32'h800, "no buffer");
      $display("test registers done");
      bus(1'b1, IDX_BUF_DEFINE, {16'h0, BUF_SAMPLE_DATA});
      bus(1'b1, IDX_XFER_LEN, 32'h10);
      bus(1'b1, IDX_CARD_COMMAND, CMD_RECORD_START | CMD_XFER_START);
      triggerIn <= 1'b1;
      rchk(IDX_CARD_STATUS, 32'h7, 32'h0, "early trigger");
      triggerIn <= 1'b0;
      poll(ST_ARMED);
      chk("beats early", 32'h0, 32'(beats));
      triggerIn <= 1'b1;
      poll(ST_XFER_DONE);
      triggerIn <= 1'b0;
      chk("beats", 32'h8, 32'(beats));
      chk("status", 32'h203, rd & 32'he07);
      rchk(IDX_AVAIL_BYTES, '1, 32'h10, "delivered");
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_START);
      rchk(IDX_CARD_STATUS, 32'h800, 32'h800, "reuse");
      $display("test record done");
      stall <= 1'b1;
      bus(1'b1, IDX_BUF_DEFINE, {16'h0, BUF_SAMPLE_DATA});
      bus(1'b1, IDX_XFER_LEN, 32'h80);
      nb = beats;
      bus(1'b1, IDX_WAIT_TIMEOUT, 32'h8);
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_START | CMD_XFER_WAIT);
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_STOP);
      rchk(IDX_CARD_STATUS, 32'h1200, 32'h1000, "stopped");
      chk("beats stalled", 32'(nb), 32'(beats));
      bus(1'b1, IDX_BUF_INVALIDATE, {16'h0, BUF_SAMPLE_DATA});
      stall <= 1'b0;
      bus(1'b1, IDX_BUF_DEFINE, {16'h0, BUF_SAMPLE_DATA});
      bus(1'b1, IDX_NOTIFY_SIZE, 32'h4);
      bus(1'b1, IDX_XFER_LEN, 32'h20);
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_START | CMD_XFER_WAIT);
      rchk(IDX_CARD_STATUS, 32'hb00, 32'h100, "block");
      $display("test transfer done");
      bus(1'b1, IDX_MEMORY_TEST, 32'h1);
      bus(1'b1, IDX_TEST_ADDR, 32'h5);
      bus(1'b1, IDX_TEST_DATA, 32'h1234);
      rchk(IDX_TEST_DATA, 32'hffff, 32'h1234, "test data");
      bus(1'b1, IDX_CARD_COMMAND, CMD_XFER_START);
      rchk(IDX_CARD_STATUS, 32'hb00, 32'h100, "ignored");
      bus(1'b1, IDX_MEMORY_TEST, 32'h0);
      $display("test memory done");
      test_done();
   end
   // hang guard
   initial
   begin
      #1000000;
      n_errors++;
      test_done();
   end
endmodule // testbench
